/* design/branch_target.sv */
`default_nettype none
module branch_target
    import coproc_cond_pkg::*;
#(
    parameter int W = 32
) (
    // Operands
    input wire logic [W-1:0] disp,
    input wire logic is_long,
    input wire logic [W-1:0] scan_ptr,
    // Result
    output logic [W-1:0] target
);
    // Short displacement needs its sign bit inside the word
    if (W < 16) begin : g_width_check
        $error("branch_target needs at least 16 bits");
    end

    logic [W-1:0] disp_ext;

    always_comb begin
        // Short form widened with its sign bit
        disp_ext = is_long ? disp : {{(W-16){disp[15]}}, disp[15:0]}; // RQ3
        target = scan_ptr + disp_ext; // RQ2
    end
endmodule : branch_target
`default_nettype wire

/* design/coproc_cond_exec.sv */
// What this block does
// RQ1: Branch with false condition continues at the next sequential instruction.
// RQ2: Branch with true condition targets scan pointer plus displacement.
// RQ3: Displacement is 16 or 32 bits; short form is sign-extended.
// RQ4: Set opcode: select id bits 11-9, 001 in 8-6, address mode 5-0.
// RQ5: Set selector word goes to the interface register to start evaluation.
// RQ6: Set may carry coprocessor words then zero to five address words.
// RQ7: Set writes the word after the opcode, then reads the response.
// RQ8: Set with false condition writes an all-zero byte to the address.
// RQ9: Set with true condition writes an all-ones byte to the address.
// RQ10: Loop opcode: select id 11-9, 001001 in 8-3, counter register 2-0.
// RQ11: Loop selector word goes to the interface register; extras may follow.
// RQ12: Loop displacement is 16 bits, sign-extended for the destination.
// RQ13: Loop with true condition falls through, counter untouched.
// RQ14: Loop with false condition decrements only the counter's low word.
// RQ15: Counter low word at minus one falls through, else branches.
// RQ16: Coprocessor may request services before returning its condition.
// RQ17: Final condition arrives as a null primitive.
// RQ18: Non-null primitive allowing come-again without it is a protocol violation.
// RQ19: Branch opcode 1111 in 15-12; whole opcode goes to the interface register.
// RQ20: Set to a non data-alterable byte location is an illegal instruction.
`default_nettype none
module coproc_cond_exec
    import coproc_cond_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Instruction from the decoder
    input wire logic start_valid,
    input wire cond_cmd_t start_cmd,
    output logic start_ready,
    // Interface register write
    output logic cir_wr_valid,
    output logic [15:0] cir_wr_data,
    output logic [2:0] coprocessor_select_id,
    input wire logic cir_wr_ready,
    // Response register read
    output logic resp_rd,
    input wire logic resp_valid,
    input wire cp_resp_t resp,
    // Service requests
    output logic svc_req,
    output cp_resp_t svc_resp,
    input wire logic svc_done,
    // Flag byte write
    output logic bw_valid,
    output byte_wr_t bw,
    input wire logic bw_ready,
    // Loop counter write back
    output logic dreg_wr,
    output logic [2:0] dreg_wr_idx,
    output logic [31:0] dreg_wr_data,
    // Completion
    output logic done_valid,
    output cond_done_t done
);
    seq_state_t state_q, state_d;
    cond_cmd_t cmd_q, cmd_d;
    cp_resp_t resp_q, resp_d;
    byte_wr_t bw_q, bw_d;
    cond_done_t done_q, done_d;
    logic done_valid_q, done_valid_d;
    logic [15:0] cir_data_q, cir_data_d;
    logic dreg_wr_q, dreg_wr_d;
    logic [31:0] dreg_data_q, dreg_data_d;

    logic is_loop, is_set, is_branch, st_loop, st_set, st_branch, st_legal;
    logic [31:0] target;
    logic [15:0] count_dec;

    function automatic logic kind_loop(input logic [15:0] op);
        kind_loop = op[8:3] == LOOP_PATTERN; // RQ10
    endfunction : kind_loop

    function automatic logic kind_set(input logic [15:0] op);
        kind_set = !kind_loop(op) && op[8:6] == SET_PATTERN; // RQ4
    endfunction : kind_set

    function automatic logic kind_branch(input logic [15:0] op);
        kind_branch = op[8:7] == BRANCH_PATTERN;
    endfunction : kind_branch

    // Only data-alterable byte modes may take the flag
    function automatic logic ea_alterable(input logic [5:0] ea);
        logic ok;
        ok = 1'b1;
        if (ea[5:3] == EA_AREG) begin
            ok = 1'b0;
        end else if (ea[5:3] == EA_SPECIAL) begin
            ok = ea[2:0] <= EA_ABS_LAST;
        end
        ea_alterable = ok; // RQ20
    endfunction : ea_alterable

    always_comb begin
        is_loop = kind_loop(cmd_q.opword);
        is_set = kind_set(cmd_q.opword);
        is_branch = kind_branch(cmd_q.opword);
        st_loop = kind_loop(start_cmd.opword);
        st_set = kind_set(start_cmd.opword);
        st_branch = kind_branch(start_cmd.opword);
        st_legal = start_cmd.opword[FLINE_HI:FLINE_LO] == FLINE // RQ19
            && (st_loop || st_branch || (st_set && ea_alterable(start_cmd.opword[5:0])));
        count_dec = cmd_q.counter[15:0] - COUNT_STEP; // RQ14
    end

    // Loop form always uses the short displacement
    branch_target #(.W(32)) u_target (
        .disp(cmd_q.disp),
        .is_long(is_branch && cmd_q.opword[LONG_BIT]), // RQ3 RQ12
        .scan_ptr(cmd_q.scan_ptr), // RQ2
        .target(target)
    );

    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        resp_d = resp_q;
        bw_d = bw_q;
        done_d = done_q;
        done_valid_d = 1'b0;
        cir_data_d = cir_data_q;
        dreg_wr_d = 1'b0;
        dreg_data_d = dreg_data_q;
        case (state_q)
            ST_IDLE: begin
                if (start_valid) begin
                    cmd_d = start_cmd;
                    if (st_legal) begin
                        // Selector word, or the whole opcode for the branch form
                        cir_data_d = st_branch ? start_cmd.opword
                            : start_cmd.selword; // RQ5 RQ7 RQ11 RQ19
                        state_d = ST_CIR_WR;
                    end else begin
                        done_d = '{next_ptr: start_cmd.next_ptr, taken: 1'b0,
                                   illegal: 1'b1, violation: 1'b0}; // RQ20
                        done_valid_d = 1'b1;
                    end
                end
            end
            ST_CIR_WR: begin
                if (cir_wr_ready) begin
                    state_d = ST_RESP_RD; // RQ7
                end
            end
            ST_RESP_RD: begin
                if (resp_valid) begin
                    resp_d = resp;
                    done_d = '{next_ptr: cmd_q.next_ptr, taken: 1'b0,
                               illegal: 1'b0, violation: 1'b0};
                    if (resp.null_prim) begin // RQ17
                        state_d = ST_IDLE;
                        if (is_loop) begin
                            if (!resp.cond_true) begin
                                dreg_wr_d = 1'b1; // RQ14
                                dreg_data_d = {cmd_q.counter[31:16], count_dec};
                                if (count_dec != COUNT_END) begin // RQ15
                                    done_d.next_ptr = target;
                                    done_d.taken = 1'b1;
                                end
                            end
                            done_valid_d = 1'b1; // RQ13
                        end else if (is_set) begin
                            bw_d.to_dreg = cmd_q.opword[5:3] == EA_DREG;
                            bw_d.dreg = cmd_q.opword[2:0];
                            bw_d.addr = cmd_q.ea_addr; // RQ6
                            bw_d.data = resp.cond_true ? BYTE_TRUE : BYTE_FALSE; // RQ8 RQ9
                            state_d = ST_BYTE_WR;
                        end else begin
                            if (resp.cond_true) begin
                                done_d.next_ptr = target; // RQ2
                                done_d.taken = 1'b1;
                            end
                            done_valid_d = 1'b1; // RQ1
                        end
                    end else if (resp.ca_allowed && !resp.come_again) begin
                        done_d.violation = 1'b1; // RQ18
                        done_valid_d = 1'b1;
                        state_d = ST_IDLE;
                    end else begin
                        state_d = ST_SERVICE; // RQ16
                    end
                end
            end
            ST_SERVICE: begin
                if (svc_done) begin
                    // A primitive without come-again ends the instruction here
                    if (resp_q.come_again) begin
                        state_d = ST_RESP_RD;
                    end else begin
                        done_valid_d = 1'b1;
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_BYTE_WR: begin
                if (bw_ready) begin
                    done_valid_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cmd_q <= '0;
            resp_q <= '0;
            bw_q <= '0;
            done_q <= '0;
            done_valid_q <= 1'b0;
            cir_data_q <= '0;
            dreg_wr_q <= 1'b0;
            dreg_data_q <= '0;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            resp_q <= resp_d;
            bw_q <= bw_d;
            done_q <= done_d;
            done_valid_q <= done_valid_d;
            cir_data_q <= cir_data_d;
            dreg_wr_q <= dreg_wr_d;
            dreg_data_q <= dreg_data_d;
        end
    end

    // Handshakes straight from the state; data from flip-flops
    assign start_ready = state_q == ST_IDLE;
    assign cir_wr_valid = state_q == ST_CIR_WR;
    assign cir_wr_data = cir_data_q;
    assign coprocessor_select_id = cmd_q.opword[COPROCESSOR_SELECT_ID_HI:COPROCESSOR_SELECT_ID_LO]; // RQ4 RQ10
    assign resp_rd = state_q == ST_RESP_RD;
    assign svc_req = state_q == ST_SERVICE;
    assign svc_resp = resp_q;
    assign bw_valid = state_q == ST_BYTE_WR;
    assign bw = bw_q;
    assign dreg_wr = dreg_wr_q;
    assign dreg_wr_idx = cmd_q.opword[2:0]; // RQ14
    assign dreg_wr_data = dreg_data_q;
    assign done_valid = done_valid_q;
    assign done = done_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic null_in, false_in, true_in;
    assign null_in = resp_rd && resp_valid && resp.null_prim;
    assign false_in = null_in && !resp.cond_true;
    assign true_in = null_in && resp.cond_true;

    AST_FALSE_BRANCH_FALLS: assert property ( // RQ1
        is_branch && !is_loop && !is_set && false_in
        |=> done_valid && !done.taken && done.next_ptr == cmd_q.next_ptr)
        else $error("false branch did not fall through");
    AST_TRUE_BRANCH_TARGET: assert property ( // RQ2
        is_branch && !is_loop && !is_set && true_in && !cmd_q.opword[LONG_BIT]
        |=> done_valid && done.taken
            && done.next_ptr == cmd_q.scan_ptr + {{16{cmd_q.disp[15]}}, cmd_q.disp[15:0]})
        else $error("short branch target wrong");
    AST_SEL_WORD_SENT: assert property ( // RQ7
        start_ready && start_valid && st_legal && !st_branch
        |=> cir_wr_valid && cir_wr_data == $past(start_cmd.selword))
        else $error("selector word not sent");
    AST_OPWORD_SENT: assert property ( // RQ19
        start_ready && start_valid && st_legal && st_branch && !st_loop && !st_set
        |=> cir_wr_valid && cir_wr_data == $past(start_cmd.opword))
        else $error("branch opcode not sent");
    AST_SET_BYTE: assert property ( // RQ9
        is_set && null_in
        |=> bw_valid && bw.data == ($past(resp.cond_true) ? BYTE_TRUE : BYTE_FALSE)
            && bw.addr == cmd_q.ea_addr)
        else $error("flag byte wrong");
    AST_LOOP_TRUE_KEEPS: assert property ( // RQ13
        is_loop && true_in |=> done_valid && !dreg_wr && !done.taken)
        else $error("loop true touched counter");
    AST_LOOP_DEC: assert property ( // RQ14
        is_loop && false_in |=> dreg_wr
            && dreg_wr_data == {cmd_q.counter[31:16], cmd_q.counter[15:0] - COUNT_STEP})
        else $error("loop decrement wrong");
    AST_LOOP_END: assert property ( // RQ15
        dreg_wr |-> done_valid && (done.taken == (dreg_wr_data[15:0] != COUNT_END)))
        else $error("loop exit decision wrong");
    AST_VIOLATION: assert property ( // RQ18
        resp_rd && resp_valid && !resp.null_prim && resp.ca_allowed && !resp.come_again
        |=> done_valid && done.violation && start_ready)
        else $error("missing come-again not flagged");
    AST_ILLEGAL_SET: assert property ( // RQ20
        start_ready && start_valid && !st_legal
        |=> done_valid && done.illegal && !cir_wr_valid)
        else $error("illegal set not refused");

    COV_BRANCH_TAKEN: cover property (is_branch && true_in ##1 done_valid);
    COV_SERVICE_LOOP: cover property (svc_req && svc_done ##1 resp_rd);
    COV_LOOP_BRANCH: cover property (dreg_wr && done.taken);
    COV_SET_WRITE: cover property (bw_valid && bw_ready);
endmodule : coproc_cond_exec
`default_nettype wire

/* design/coproc_cond_pkg.sv */
`default_nettype none
package coproc_cond_pkg;
    // Opcode field positions and patterns
    localparam logic [3:0] FLINE = 4'hF;
    localparam logic [2:0] SET_PATTERN = 3'h1;
    localparam logic [5:0] LOOP_PATTERN = 6'h09;
    localparam logic [1:0] BRANCH_PATTERN = 2'h1;
    localparam int FLINE_HI = 15;
    localparam int FLINE_LO = 12;
    localparam int COPROCESSOR_SELECT_ID_HI = 11;
    localparam int COPROCESSOR_SELECT_ID_LO = 9;
    localparam int LONG_BIT = 6;
    localparam int SEL_HI = 5;

    // Effective address modes
    localparam logic [2:0] EA_DREG = 3'h0;
    localparam logic [2:0] EA_AREG = 3'h1;
    localparam logic [2:0] EA_SPECIAL = 3'h7;
    localparam logic [2:0] EA_ABS_LAST = 3'h1;

    // Written values
    localparam logic [7:0] BYTE_TRUE = 8'hFF;
    localparam logic [7:0] BYTE_FALSE = 8'h00;
    localparam logic [15:0] COUNT_END = 16'hFFFF;
    localparam logic [15:0] COUNT_STEP = 16'h0001;

    typedef struct packed {
        logic [15:0] opword;
        logic [15:0] selword;
        logic [31:0] disp;
        logic [31:0] scan_ptr;
        logic [31:0] next_ptr;
        logic [31:0] ea_addr;
        logic [31:0] counter;
    } cond_cmd_t;

    typedef struct packed {
        logic null_prim;
        logic come_again;
        logic ca_allowed;
        logic cond_true;
    } cp_resp_t;

    typedef struct packed {
        logic [31:0] next_ptr;
        logic taken;
        logic illegal;
        logic violation;
    } cond_done_t;

    typedef struct packed {
        logic to_dreg;
        logic [2:0] dreg;
        logic [31:0] addr;
        logic [7:0] data;
    } byte_wr_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CIR_WR = 3'h1,
        ST_RESP_RD = 3'h3,
        ST_SERVICE = 3'h2,
        ST_BYTE_WR = 3'h7
    } seq_state_t;
endpackage : coproc_cond_pkg
`default_nettype wire

/* dv/cp_model.sv */
`default_nettype none
module cp_model
    import coproc_cond_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Interface register write
    input wire logic cir_wr_valid,
    input wire logic [15:0] cir_wr_data,
    output var logic cir_wr_ready,
    // Response register read
    input wire logic resp_rd,
    output var logic resp_valid,
    output var cp_resp_t resp
);
    timeunit 1ns;
    timeprecision 1ps;
    // Primitives still to hand out, the last one a null carrying the condition
    cp_resp_t script[$];
    int lat;
    int cnt;
    logic hs;
    logic [15:0] last_cir;

    initial begin
        cir_wr_ready = 1'b0;
        resp_valid = 1'b0;
        resp = 4'h0;
        lat = 0;
        cnt = 0;
        last_cir = 16'h0000;
    end

    always @(posedge mclk) begin
        hs = (cir_wr_valid && cir_wr_ready) || (resp_rd && resp_valid);
        if (cir_wr_valid && cir_wr_ready) begin
            last_cir = cir_wr_data;
        end
        if (resp_rd && resp_valid) begin
            script.delete(0);
        end
        #1;
        if (rst || hs) begin
            cnt = 0;
        end else if (cir_wr_valid || resp_rd) begin
            cnt++;
        end
        // Slow answers come after lat idle cycles, lat+1 for the response read right after a register write
        cir_wr_ready = !rst && !hs && cir_wr_valid && cnt > lat;
        resp_valid = !rst && !hs && resp_rd && cnt > lat && script.size() > 0;
        // Released bus shows a changing pattern, not the last value
        resp = resp_valid ? script[0] : ~resp;
    end
endmodule : cp_model
`default_nettype wire

/* dv/tb.sv */
`default_nettype none
module tb
    import coproc_cond_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst, start_valid, start_ready, cir_wr_valid, cir_wr_ready, resp_rd;
    logic resp_valid, svc_req, svc_done, bw_valid, bw_ready, dreg_wr, done_valid;
    cond_cmd_t start_cmd;
    logic [15:0] cir_wr_data;
    logic [2:0] cp_id, dreg_wr_idx;
    cp_resp_t resp, svc_resp, svg;
    byte_wr_t bw, bwg;
    logic [31:0] dreg_wr_data, dw;
    cond_done_t done, dn;
    int n_fail = 0;
    int n_compared = 0;
    int nd, nb, ndw;

    coproc_cond_exec uut (.mclk(mclk), .rst(rst), .start_valid(start_valid),
        .start_cmd(start_cmd), .start_ready(start_ready), .cir_wr_valid(cir_wr_valid),
        .cir_wr_data(cir_wr_data), .coprocessor_select_id(cp_id),
        .cir_wr_ready(cir_wr_ready), .resp_rd(resp_rd), .resp_valid(resp_valid),
        .resp(resp), .svc_req(svc_req), .svc_resp(svc_resp), .svc_done(svc_done),
        .bw_valid(bw_valid), .bw(bw), .bw_ready(bw_ready), .dreg_wr(dreg_wr),
        .dreg_wr_idx(dreg_wr_idx), .dreg_wr_data(dreg_wr_data),
        .done_valid(done_valid), .done(done));
    cp_model cp (.mclk(mclk), .rst(rst), .cir_wr_valid(cir_wr_valid),
        .cir_wr_data(cir_wr_data), .cir_wr_ready(cir_wr_ready), .resp_rd(resp_rd),
        .resp_valid(resp_valid), .resp(resp));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Service and byte write partners; both answer in the first cycle of a request
    always @(posedge mclk) begin
        if (!rst && done_valid) begin
            dn = done;
            nd++;
        end
        if (!rst && bw_valid && bw_ready) begin
            bwg = bw;
            nb++;
        end
        if (!rst && dreg_wr) begin
            dw = dreg_wr_data;
            ndw++;
        end
        if (!rst && svc_req && svc_done) begin
            svg = svc_resp;
        end
        #1;
        svc_done = svc_req;
        bw_ready = bw_valid && !bw_ready;
    end

    task automatic chk(input string name, input logic [95:0] seen, input logic [95:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    function automatic logic [31:0] sx(input logic [31:0] d);
        return {{16{d[15]}}, d[15:0]};
    endfunction : sx

    // Runs one instruction; appends fin to the partner script after any primitives loaded beforehand
    task automatic exec(input logic [15:0] op, input logic [15:0] sel, input logic [31:0] d,
            input logic [31:0] cnt, input int lat, input logic [3:0] fin);
        nd = 0;
        nb = 0;
        ndw = 0;
        cp.lat = lat;
        cp.script.push_back(fin);
        start_cmd = '{op, sel, d, 32'h0000_1000, 32'h0000_1008, 32'h0000_2040, cnt};
        start_valid = 1'b1;
        do @(posedge mclk); while (!start_ready);
        #1 start_valid = 1'b0;
        for (int i = 0; i < 80 && nd == 0; i++) @(posedge mclk);
        #1 chk("done count", nd, 1);
    endtask : exec

    task automatic t_branch();
        exec(16'hF281, 16'h0000, 32'h0000_FFF0, 0, 0, 4'h8);
        chk("cir word", cp.last_cir, 16'hF281);
        chk("false flow", {dn.taken, dn.next_ptr}, {1'b0, 32'h0000_1008});
        cp.script.push_back(4'h6);
        exec(16'hF281, 16'h0000, 32'h0000_FFF0, 0, 2, 4'h9);
        chk("short target", {dn.taken, dn.next_ptr}, {1'b1, 32'h0000_0FF0});
        chk("svc prim", svg, 4'h6);
        exec(16'hF2C1, 16'h0000, 32'h0001_0004, 0, 0, 4'h9);
        chk("long target", dn.next_ptr, 32'h0001_1004);
    endtask : t_branch

    task automatic t_set();
        for (int c = 0; c < 2; c++) begin
            exec(16'hF253, 16'h0015, 0, 0, c, {3'b100, c[0]});
            chk("set cir", cp.last_cir, 16'h0015);
            chk("set id", cp_id, 3'h1);
            chk("set byte", {nb, bwg.to_dreg, bwg.addr, bwg.data},
                {32'd1, 1'b0, 32'h0000_2040, c[0] ? 8'hFF : 8'h00});
        end
        exec(16'hF245, 16'h0015, 0, 0, 0, 4'h9);
        chk("set dreg", {bwg.to_dreg, bwg.dreg, bwg.data}, {1'b1, 3'h5, 8'hFF});
        cp.script.delete();
        // Immediate mode cannot take the flag
        exec(16'hF27C, 16'h0015, 0, 0, 0, 4'h9);
        chk("illegal ea", {dn.illegal, nb}, {1'b1, 32'd0});
        cp.script.delete();
    endtask : t_set

    task automatic t_loop();
        exec(16'hF24B, 16'h0007, 32'h0000_FFFE, 32'h1234_0005, 0, 4'h9);
        chk("loop true", {ndw, dn.taken, cp.last_cir}, {32'd0, 1'b0, 16'h0007});
        exec(16'hF24B, 16'h0007, 32'h0000_FFFE, 32'h1234_0005, 1, 4'h8);
        chk("dec low", {ndw, dreg_wr_idx, dw}, {32'd1, 3'h3, 32'h1234_0004});
        chk("loop back", {dn.taken, dn.next_ptr},
            {1'b1, sx(32'h0000_FFFE) + 32'h1000});
        exec(16'hFA4E, 16'h0007, 32'h0000_0010, 32'hABCD_0000, 0, 4'h8);
        chk("wrap", {dw, dn.taken, dn.next_ptr},
            {32'hABCD_FFFF, 1'b0, 32'h0000_1008});
        chk("wrap id", {cp_id, dreg_wr_idx}, {3'h5, 3'h6});
    endtask : t_loop

    task automatic t_violation();
        cp.script.push_back(4'h2);
        exec(16'hF281, 16'h0000, 0, 0, 0, 4'h9);
        chk("violation", {dn.violation, dn.taken}, {1'b1, 1'b0});
        cp.script.delete();
        // Serviced primitive without come-again ends the instruction plainly
        cp.script.push_back(4'h0);
        exec(16'hF281, 16'h0000, 0, 0, 0, 4'h9);
        chk("plain end", {dn.violation, dn.taken, dn.next_ptr},
            {2'b00, 32'h0000_1008});
        cp.script.delete();
    endtask : t_violation

    initial begin
        rst = 1'b1;
        start_valid = 1'b0;
        start_cmd = '0;
        svc_done = 1'b0;
        bw_ready = 1'b0;
        repeat (12) @(posedge mclk);
        #1 rst = 1'b0;
        t_branch();
        t_set();
        t_loop();
        t_violation();
        end_sim();
    end

    // Watchdog: a few hundred cycles suffice for every scenario
    initial begin
        #200000;
        n_fail++;
        end_sim();
    end
endmodule : tb
`default_nettype wire
